// ---- include/exec_pkg.sv ----
// Shared constants and types of the flow-control and bit-operation executor
package exec_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map of the plain software port
	localparam logic [3:0] ADDR_CMD     = 4'h0;
	localparam logic [3:0] ADDR_OPR     = 4'h1;
	localparam logic [3:0] ADDR_OPB     = 4'h2;
	localparam logic [3:0] ADDR_TARGET  = 4'h3;
	localparam logic [3:0] ADDR_PC      = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h5;
	localparam logic [3:0] ADDR_ZPTR    = 4'h6;
	localparam logic [3:0] ADDR_SP      = 4'h7;
	localparam logic [3:0] ADDR_REGADDR = 4'h8;
	localparam logic [3:0] ADDR_REGDATA = 4'h9;
	localparam logic [3:0] ADDR_CYCLES  = 4'hA;

	// Field positions
	localparam int unsigned CMD_OP_LSB       = 0;
	localparam int unsigned CMD_TWO_WORD_BIT = 5;
	localparam int unsigned CMD_BUSY_BIT     = 8;
	localparam int unsigned CMD_ERR_BIT      = 9;
	localparam int unsigned OPR_DST_LSB      = 0;
	localparam int unsigned OPR_SRC_LSB      = 5;
	localparam int unsigned OPB_BIT_LSB      = 0;
	localparam int unsigned OPB_IO_LSB       = 3;
	localparam int unsigned OPB_K_LSB        = 8;

	// Status register bit positions
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_Z = 1;
	localparam int unsigned FLG_N = 2;
	localparam int unsigned FLG_V = 3;
	localparam int unsigned FLG_S = 4;
	localparam int unsigned FLG_H = 5;
	localparam int unsigned FLG_T = 6;
	localparam int unsigned FLG_I = 7;

	// Values after reset
	localparam logic [15:0] RST_PC   = 16'h0000;
	localparam logic [15:0] RST_Z    = 16'h0000;
	localparam logic [7:0]  RST_STATUS_REGISTER = 8'h00;
	localparam logic [5:0]  RST_SP   = 6'h3F;

	// Operand store: registers, I/O space, byte stack
	localparam int          MEM_DEPTH = 128;
	localparam int          MEM_AW    = 7;
	localparam int          DATA_W    = 8;
	localparam logic [6:0]  GPR_BASE  = 7'h00;
	localparam logic [6:0]  IO_BASE   = 7'h20;
	localparam logic [6:0]  STK_BASE  = 7'h40;
	localparam logic [5:0]  SP_ONE    = 6'h01;
	localparam logic [5:0]  SP_TWO    = 6'h02;

	// Program counter steps, in words
	localparam logic [15:0] PC_STEP      = 16'h0001;
	localparam logic [15:0] PC_SKIP_ONE  = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO  = 16'h0003;
	localparam logic [15:0] PC_CALL_WRDS = 16'h0002;

	// Cycle counts
	localparam logic [2:0] CYC_ONE           = 3'h1;
	localparam logic [2:0] CYC_TAKEN         = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE      = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO      = 3'h3;
	localparam logic [2:0] CYC_IO_BIT        = 3'h2;
	localparam logic [2:0] CYC_INDIRECT_CALL = 3'h3;
	localparam logic [2:0] CYC_DIRECT_CALL   = 3'h4;
	localparam logic [2:0] CYC_RETURN        = 3'h4;

	localparam logic [4:0] OP_COUNT = 5'h1D;

	typedef enum logic [4:0] {
		OP_INDIRECT_CALL, OP_DIRECT_CALL, OP_SUB_RETURN, OP_INT_RETURN,
		OP_CMP_SKIP_EQ, OP_CMP_IMM, OP_SKIP_REG_CLR, OP_SKIP_REG_SET,
		OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_HALF_SET, OP_BRANCH_HALF_CLR, OP_BRANCH_OVF_SET,
		OP_BRANCH_OVF_CLR, OP_BRANCH_IRQ_EN, OP_BRANCH_IRQ_DIS,
		OP_IO_BIT_SET, OP_IO_BIT_CLR, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
		OP_NIBBLE_SWAP, OP_BIT_TO_TFLAG, OP_TFLAG_TO_BIT,
		OP_STATUS_SET, OP_STATUS_CLR
	} op_e;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_HOLD} state_e;

endpackage

// ---- rtl/exec_regmem.sv ----
// Operand store: one write port, two registered read ports
`timescale 1ns/10ps
module exec_regmem (
	// Clock
	input  wire logic                         clk,
	// Write port
	input  wire logic                         we,
	input  wire logic [exec_pkg::MEM_AW-1:0]  waddr,
	input  wire logic [exec_pkg::DATA_W-1:0]  wdata,
	// Read ports
	input  wire logic [exec_pkg::MEM_AW-1:0]  raddr_a,
	input  wire logic [exec_pkg::MEM_AW-1:0]  raddr_b,
	output logic      [exec_pkg::DATA_W-1:0]  rdata_a,
	output logic      [exec_pkg::DATA_W-1:0]  rdata_b
);
	import exec_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] qa;
		logic [DATA_W-1:0] qb;
	} rd_s;

	logic [DATA_W-1:0] mem [MEM_DEPTH];
	rd_s               rd_ff;
	rd_s               nxt_rd;

	// Read during write returns the old byte
	always_comb begin
		nxt_rd.qa = mem[raddr_a];
		nxt_rd.qb = mem[raddr_b];
	end

	always_ff @(posedge clk) begin
		rd_ff <= nxt_rd;
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata_a = rd_ff.qa;
	assign rdata_b = rd_ff.qb;

endmodule

// ---- rtl/flow_bit_exec.sv ----
// Executor for flow-control, skip, branch and bit operations
`timescale 1ns/10ps
module flow_bit_exec (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	// Execution state
	output logic             busy,
	output logic             done,
	output logic      [15:0] pc_out,
	output logic      [7:0]  status_out
);
	import exec_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		state_e      st;
		op_e         op;
		logic        two_word;
		logic [4:0]  dst;
		logic [4:0]  src;
		logic [2:0]  bsel;
		logic [4:0]  ioa;
		logic [7:0]  kimm;
		logic [15:0] target;
		logic [15:0] pc;
		logic [7:0]  status_register;
		logic [15:0] z;
		logic [5:0]  sp;
		logic [6:0]  regaddr;
		logic [6:0]  a_addr;
		logic [6:0]  b_addr;
		logic [2:0]  cnt;
		logic [2:0]  cycles;
		logic        push_hi;
		logic [7:0]  ret_hi;
		logic [15:0] rdata;
		logic        busy;
		logic        done;
		logic        err;
	} exec_s;

	localparam exec_s RST_VAL = '{
		st:      ST_IDLE,
		op:      OP_INDIRECT_CALL,
		pc:      RST_PC,
		status_register:    RST_STATUS_REGISTER,
		z:       RST_Z,
		sp:      RST_SP,
		default: '0
	};

	exec_s             state_ff;
	exec_s             nxt_state;

	logic              mem_we;
	logic [MEM_AW-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [MEM_AW-1:0] mem_raddr_a;
	logic [DATA_W-1:0] mem_qa;
	logic [DATA_W-1:0] mem_qb;

	////////////////////////////////////////////////////////////////////////
	// Operand store

	// Idle: port A serves software reads of the store
	assign mem_raddr_a = (state_ff.st == ST_IDLE) ? state_ff.regaddr
	                                              : state_ff.a_addr;

	exec_regmem u_regmem (
		.clk     (clk),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.raddr_a (mem_raddr_a),
		.raddr_b (state_ff.b_addr),
		.rdata_a (mem_qa),
		.rdata_b (mem_qb)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [15:0] rd_val;
		logic [15:0] ret_pc;
		logic [15:0] koff;
		logic [7:0]  res;
		logic [8:0]  diff;
		logic [2:0]  cyc;
		logic        take;
		logic        skip;
		op_e         new_op;
		rd_val    = '0;
		ret_pc    = state_ff.pc + PC_STEP;
		koff      = {{9{state_ff.target[6]}}, state_ff.target[6:0]};
		res       = mem_qa;
		diff      = {1'b0, mem_qa} - {1'b0, state_ff.kimm};
		cyc       = CYC_ONE;
		take      = 1'b0;
		skip      = 1'b0;
		new_op    = op_e'(wdata[CMD_OP_LSB +: 5]);
		nxt_state = state_ff;
		nxt_state.done  = 1'b0;
		nxt_state.rdata = '0;
		mem_we    = 1'b0;
		mem_waddr = state_ff.regaddr;
		mem_wdata = wdata[7:0];

		// Register reads, answered in the next cycle
		if (rd_en) begin
			case (addr)
				ADDR_CMD: begin
					rd_val[CMD_OP_LSB +: 5]   = state_ff.op;
					rd_val[CMD_TWO_WORD_BIT]  = state_ff.two_word;
					rd_val[CMD_BUSY_BIT]      = state_ff.busy;
					rd_val[CMD_ERR_BIT]       = state_ff.err;
				end
				ADDR_OPR: begin
					rd_val[OPR_DST_LSB +: 5] = state_ff.dst;
					rd_val[OPR_SRC_LSB +: 5] = state_ff.src;
				end
				ADDR_OPB: begin
					rd_val[OPB_BIT_LSB +: 3] = state_ff.bsel;
					rd_val[OPB_IO_LSB +: 5]  = state_ff.ioa;
					rd_val[OPB_K_LSB +: 8]   = state_ff.kimm;
				end
				ADDR_TARGET:  rd_val = state_ff.target;
				ADDR_PC:      rd_val = state_ff.pc;
				ADDR_STATUS:  rd_val[7:0] = state_ff.status_register;
				ADDR_ZPTR:    rd_val = state_ff.z;
				ADDR_SP:      rd_val[5:0] = state_ff.sp;
				ADDR_REGADDR: rd_val[6:0] = state_ff.regaddr;
				ADDR_REGDATA: rd_val[7:0] = mem_qa;
				ADDR_CYCLES:  rd_val[2:0] = state_ff.cycles;
				default:      rd_val = '0;
			endcase
			nxt_state.rdata = rd_val;
		end

		unique case (state_ff.st)
			ST_IDLE: begin
				// Writes while busy are dropped to keep operands stable
				if (wr_en) begin
					case (addr)
						ADDR_CMD: begin
							if (wdata[CMD_OP_LSB +: 5] >= OP_COUNT) begin
								nxt_state.err = 1'b1;
							end else begin
								nxt_state.op       = new_op;
								nxt_state.two_word = wdata[CMD_TWO_WORD_BIT];
								nxt_state.err      = 1'b0;
								nxt_state.busy     = 1'b1;
								nxt_state.st       = ST_FETCH;
								nxt_state.a_addr   = GPR_BASE |
									{2'b00, state_ff.dst};
								nxt_state.b_addr   = GPR_BASE |
									{2'b00, state_ff.src};
								case (new_op)
									OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
									OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
										nxt_state.a_addr = IO_BASE |
											{2'b00, state_ff.ioa};
									end
									OP_SUB_RETURN, OP_INT_RETURN: begin
										nxt_state.a_addr = STK_BASE |
											{1'b0, state_ff.sp + SP_ONE};
										nxt_state.b_addr = STK_BASE |
											{1'b0, state_ff.sp + SP_TWO};
									end
									default: begin
									end
								endcase
							end
						end
						ADDR_OPR: begin
							nxt_state.dst = wdata[OPR_DST_LSB +: 5];
							nxt_state.src = wdata[OPR_SRC_LSB +: 5];
						end
						ADDR_OPB: begin
							nxt_state.bsel = wdata[OPB_BIT_LSB +: 3];
							nxt_state.ioa  = wdata[OPB_IO_LSB +: 5];
							nxt_state.kimm = wdata[OPB_K_LSB +: 8];
						end
						ADDR_TARGET:  nxt_state.target  = wdata;
						ADDR_PC:      nxt_state.pc      = wdata;
						ADDR_STATUS:  nxt_state.status_register    = wdata[7:0];
						ADDR_ZPTR:    nxt_state.z       = wdata;
						ADDR_SP:      nxt_state.sp      = wdata[5:0];
						ADDR_REGADDR: nxt_state.regaddr = wdata[6:0];
						ADDR_REGDATA: mem_we = 1'b1;
						default: begin
						end
					endcase
				end
			end

			// Operand bytes appear one cycle after their address
			ST_FETCH: nxt_state.st = ST_EXEC;

			ST_EXEC: begin
				nxt_state.pc = state_ff.pc + PC_STEP;
				unique case (state_ff.op)
					OP_INDIRECT_CALL, OP_DIRECT_CALL: begin
						// Low byte now, high byte in the next cycle
						if (state_ff.op == OP_DIRECT_CALL) begin
							ret_pc       = state_ff.pc + PC_CALL_WRDS;
							nxt_state.pc = state_ff.target;
							cyc          = CYC_DIRECT_CALL;
						end else begin
							nxt_state.pc = state_ff.z;
							cyc          = CYC_INDIRECT_CALL;
						end
						mem_we            = 1'b1;
						mem_waddr         = STK_BASE | {1'b0, state_ff.sp};
						mem_wdata         = ret_pc[7:0];
						nxt_state.ret_hi  = ret_pc[15:8];
						nxt_state.push_hi = 1'b1;
					end
					OP_SUB_RETURN, OP_INT_RETURN: begin
						nxt_state.pc = {mem_qa, mem_qb};
						nxt_state.sp = state_ff.sp + SP_TWO;
						cyc          = CYC_RETURN;
						if (state_ff.op == OP_INT_RETURN) begin
							nxt_state.status_register[FLG_I] = 1'b1;
						end
					end
					OP_CMP_SKIP_EQ:  skip = (mem_qa == mem_qb);
					OP_CMP_IMM: begin
						nxt_state.status_register[FLG_Z] = (diff[7:0] == 8'h00);
						nxt_state.status_register[FLG_N] = diff[7];
						nxt_state.status_register[FLG_C] = diff[8];
						nxt_state.status_register[FLG_V] =
							(mem_qa[7] & ~state_ff.kimm[7] & ~diff[7]) |
							(~mem_qa[7] & state_ff.kimm[7] & diff[7]);
						nxt_state.status_register[FLG_H] =
							(~mem_qa[3] & state_ff.kimm[3]) |
							(state_ff.kimm[3] & diff[3]) |
							(diff[3] & ~mem_qa[3]);
					end
					OP_SKIP_REG_CLR: skip = ~mem_qa[state_ff.bsel];
					OP_SKIP_REG_SET: skip = mem_qa[state_ff.bsel];
					OP_SKIP_IO_CLR:  skip = ~mem_qa[state_ff.bsel];
					OP_SKIP_IO_SET:  skip = mem_qa[state_ff.bsel];
					OP_BRANCH_FLAG_SET:
						take = state_ff.status_register[state_ff.bsel];
					OP_BRANCH_FLAG_CLR:
						take = ~state_ff.status_register[state_ff.bsel];
					OP_BRANCH_SIGNED_GE: take = ~(state_ff.status_register[FLG_N] ^
						state_ff.status_register[FLG_V]);
					OP_BRANCH_SIGNED_LT: take = state_ff.status_register[FLG_N] ^
						state_ff.status_register[FLG_V];
					OP_BRANCH_HALF_SET:  take = state_ff.status_register[FLG_H];
					OP_BRANCH_HALF_CLR:  take = ~state_ff.status_register[FLG_H];
					OP_BRANCH_OVF_SET:   take = state_ff.status_register[FLG_V];
					OP_BRANCH_OVF_CLR:   take = ~state_ff.status_register[FLG_V];
					OP_BRANCH_IRQ_EN:    take = state_ff.status_register[FLG_I];
					OP_BRANCH_IRQ_DIS:   take = ~state_ff.status_register[FLG_I];
					OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
						// Read-modify-write of one bit keeps its neighbours
						res[state_ff.bsel] = (state_ff.op == OP_IO_BIT_SET);
						mem_we    = 1'b1;
						mem_waddr = state_ff.a_addr;
						mem_wdata = res;
						cyc       = CYC_IO_BIT;
					end
					OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
						if (state_ff.op == OP_ROTATE_LEFT) begin
							res = {mem_qa[6:0], state_ff.status_register[FLG_C]};
							nxt_state.status_register[FLG_C] = mem_qa[7];
						end else begin
							res = {state_ff.status_register[FLG_C], mem_qa[7:1]};
							nxt_state.status_register[FLG_C] = mem_qa[0];
						end
						nxt_state.status_register[FLG_Z] = (res == 8'h00);
						nxt_state.status_register[FLG_N] = res[7];
						nxt_state.status_register[FLG_V] = res[7] ^
							nxt_state.status_register[FLG_C];
						mem_we    = 1'b1;
						mem_waddr = state_ff.a_addr;
						mem_wdata = res;
					end
					OP_NIBBLE_SWAP: begin
						mem_we    = 1'b1;
						mem_waddr = state_ff.a_addr;
						mem_wdata = {mem_qa[3:0], mem_qa[7:4]};
					end
					OP_BIT_TO_TFLAG:
						nxt_state.status_register[FLG_T] = mem_qa[state_ff.bsel];
					OP_TFLAG_TO_BIT: begin
						res[state_ff.bsel] = state_ff.status_register[FLG_T];
						mem_we    = 1'b1;
						mem_waddr = state_ff.a_addr;
						mem_wdata = res;
					end
					OP_STATUS_SET:
						nxt_state.status_register[state_ff.bsel] = 1'b1;
					OP_STATUS_CLR:
						nxt_state.status_register[state_ff.bsel] = 1'b0;
				endcase
				if (skip) begin
					nxt_state.pc = state_ff.pc + (state_ff.two_word ?
						PC_SKIP_TWO : PC_SKIP_ONE);
					cyc = state_ff.two_word ? CYC_SKIP_TWO
					                        : CYC_SKIP_ONE;
				end
				if (take) begin
					nxt_state.pc = state_ff.pc + koff + PC_STEP;
					cyc          = CYC_TAKEN;
				end
				nxt_state.cycles = cyc;
				if (cyc == CYC_ONE) begin
					nxt_state.st   = ST_IDLE;
					nxt_state.busy = 1'b0;
					nxt_state.done = 1'b1;
				end else begin
					nxt_state.cnt = cyc - CYC_ONE;
					nxt_state.st  = ST_HOLD;
				end
			end

			ST_HOLD: begin
				if (state_ff.push_hi) begin
					mem_we            = 1'b1;
					mem_waddr         = STK_BASE |
						{1'b0, state_ff.sp - SP_ONE};
					mem_wdata         = state_ff.ret_hi;
					nxt_state.sp      = state_ff.sp - SP_TWO;
					nxt_state.push_hi = 1'b0;
				end
				// Pads the instruction out to its cycle count
				if (state_ff.cnt == CYC_ONE) begin
					nxt_state.st   = ST_IDLE;
					nxt_state.busy = 1'b0;
					nxt_state.done = 1'b1;
				end else begin
					nxt_state.cnt = state_ff.cnt - CYC_ONE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= RST_VAL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdata      = state_ff.rdata;
	assign busy       = state_ff.busy;
	assign done       = state_ff.done;
	assign pc_out     = state_ff.pc;
	assign status_out = state_ff.status_register;

endmodule

// ---- tb/flow_bit_exec_monitor.sv ----
// Checker for cycle counts, PC and flag effects of the executor
`timescale 1ns/10ps
module flow_bit_exec_monitor
	import exec_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [15:0] rdata,
	// Execution state
	input wire logic        busy,
	input wire logic        done,
	input wire logic [15:0] pc_out,
	input wire logic [7:0]  status_out
);
	logic [4:0]  op_q;
	logic        tw_q;
	logic        cond;
	logic [7:0]  st_q;
	logic [2:0]  cnt;
	logic [15:0] pc_q, z_q, tg_q, ob_q, br_pc;
	wire         up = wr_en && !busy;
	wire         go = up && addr == ADDR_CMD && wdata[4:0] < OP_COUNT;

	// Writes during busy are dropped, so copies follow accepted ones only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			z_q <= RST_Z;
			tg_q <= 16'h0000;
			ob_q <= 16'h0000;
			cnt <= 3'h0;
		end else begin
			if (up && addr == ADDR_ZPTR)
				z_q <= wdata;
			if (up && addr == ADDR_TARGET)
				tg_q <= wdata;
			if (up && addr == ADDR_OPB)
				ob_q <= wdata;
			if (go) begin
				op_q <= wdata[4:0];
				tw_q <= wdata[5];
				pc_q <= pc_out;
				st_q <= status_out;
				cnt <= 3'h0;
			end else if (busy)
				cnt <= cnt + 3'h1;
		end
	end

	always_comb begin
		br_pc = pc_q + {{9{tg_q[6]}}, tg_q[6:0]} + PC_STEP;
		case (op_q)
			OP_BRANCH_FLAG_SET: cond = st_q[ob_q[2:0]];
			OP_BRANCH_FLAG_CLR: cond = !st_q[ob_q[2:0]];
			OP_BRANCH_SIGNED_GE: cond = !(st_q[FLG_N] ^ st_q[FLG_V]);
			OP_BRANCH_SIGNED_LT: cond = st_q[FLG_N] ^ st_q[FLG_V];
			OP_BRANCH_HALF_SET: cond = st_q[FLG_H];
			OP_BRANCH_HALF_CLR: cond = !st_q[FLG_H];
			OP_BRANCH_OVF_SET: cond = st_q[FLG_V];
			OP_BRANCH_OVF_CLR: cond = !st_q[FLG_V];
			OP_BRANCH_IRQ_EN: cond = st_q[FLG_I];
			default: cond = !st_q[FLG_I];
		endcase
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_one_cycle;
		go && wdata[4:0] inside {OP_CMP_IMM, [OP_ROTATE_LEFT:OP_STATUS_CLR]}
		|=> busy [*2] ##1 (done && !busy);
	endproperty
	a_one_cycle: assert property (p_one_cycle)
		else $error("single-cycle op timing wrong");
	property p_io_bit_time;
		go && wdata[4:0] inside {OP_IO_BIT_SET, OP_IO_BIT_CLR}
		|=> busy [*3] ##1 done;
	endproperty
	a_io_bit_time: assert property (p_io_bit_time)
		else $error("io bit op timing wrong");
	property p_indirect_call_time;
		go && wdata[4:0] == OP_INDIRECT_CALL |=> busy [*4] ##1 done;
	endproperty
	a_indirect_call_time: assert property (p_indirect_call_time)
		else $error("indirect call timing wrong");
	property p_long_time;
		go && wdata[4:0] inside {[OP_DIRECT_CALL:OP_INT_RETURN]}
		|=> busy [*5] ##1 done;
	endproperty
	a_long_time: assert property (p_long_time)
		else $error("call or return timing wrong");
	property p_skip;
		done && op_q inside {OP_CMP_SKIP_EQ, [OP_SKIP_REG_CLR:OP_SKIP_IO_SET]}
		|-> (pc_out == pc_q + PC_STEP && cnt == 3'h2) || (pc_out == pc_q +
		(tw_q ? PC_SKIP_TWO : PC_SKIP_ONE) && cnt == (tw_q ? 3'h4 : 3'h3));
	endproperty
	a_skip: assert property (p_skip)
		else $error("skip pc or cycles wrong");
	property p_branch;
		done && op_q inside {[OP_BRANCH_FLAG_SET:OP_BRANCH_IRQ_DIS]} |-> cond
		? (pc_out == br_pc && cnt == 3'h3)
		: (pc_out == pc_q + PC_STEP && cnt == 3'h2);
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch pc or cycles wrong");
	property p_flags_kept;
		done && op_q inside {[OP_INDIRECT_CALL:OP_SUB_RETURN], OP_CMP_SKIP_EQ,
		[OP_SKIP_REG_CLR:OP_IO_BIT_CLR], OP_NIBBLE_SWAP, OP_TFLAG_TO_BIT}
		|-> status_out == st_q;
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("status changed by flag-neutral op");
	property p_interrupt_return;
		done && op_q == OP_INT_RETURN |-> status_out == (st_q | 8'h80);
	endproperty
	a_interrupt_return: assert property (p_interrupt_return)
		else $error("interrupt return status wrong");
	property p_status_bit;
		done && op_q inside {OP_STATUS_SET, OP_STATUS_CLR} |-> status_out ==
		(op_q == OP_STATUS_SET ? st_q | (8'h01 << ob_q[2:0])
		: st_q & ~(8'h01 << ob_q[2:0]));
	endproperty
	a_status_bit: assert property (p_status_bit)
		else $error("status bit op wrong");
	property p_rotate;
		done && op_q inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT}
		|-> status_out[7:4] == st_q[7:4]
		&& status_out[FLG_V] == (status_out[FLG_N] ^ status_out[FLG_C]);
	endproperty
	a_rotate: assert property (p_rotate)
		else $error("rotate flags wrong");
	property p_cmp_flags;
		done && op_q == OP_CMP_IMM |-> {status_out[7:6], status_out[FLG_S]}
		== {st_q[7:6], st_q[FLG_S]};
	endproperty
	a_cmp_flags: assert property (p_cmp_flags)
		else $error("compare touched other flags");
	property p_tflag;
		done && op_q == OP_BIT_TO_TFLAG
		|-> ((status_out ^ st_q) & 8'hBF) == 8'h00;
	endproperty
	a_tflag: assert property (p_tflag)
		else $error("bit store touched other flags");
	property p_call_pc;
		done && op_q inside {OP_INDIRECT_CALL, OP_DIRECT_CALL}
		|-> pc_out == (op_q == OP_INDIRECT_CALL ? z_q : tg_q);
	endproperty
	a_call_pc: assert property (p_call_pc)
		else $error("call target wrong");
endmodule

bind flow_bit_exec flow_bit_exec_monitor mon (.clk, .rst_n, .addr, .wdata,
	.wr_en, .rd_en, .rdata, .busy, .done, .pc_out, .status_out);

// ---- tb/flow_bit_exec_tb.sv ----
// Self-checking bench of the flow and bit executor against a model
`timescale 1ns/10ps
module flow_bit_exec_tb;
	import exec_pkg::*;
	logic        clk, rst_n, wr_en, rd_en;
	logic [3:0]  addr;
	logic [15:0] wdata, v;
	logic [15:0] rdata, pc_out;
	logic        busy, done;
	logic [7:0]  status_out;
	int          failures, check_count;
	logic [31:0] seed;
	logic [7:0]  m [MEM_DEPTH];
	logic [15:0] pc_m, z_m, tg_m, opr_m, opb_m;
	logic [7:0]  st_m;
	logic [5:0]  sp_m;
	logic [2:0]  n_m;
	logic [6:0]  wa;
	logic        hung;

	flow_bit_exec dut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
		.rdata, .busy, .done, .pc_out, .status_out);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic rnd(output logic [15:0] r);
		repeat (16) seed = lfsr(seed);
		r = seed[15:0];
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	//////////////////////////////////////////
	// Reference model, one instruction
	task automatic model(input logic [4:0] op, input logic tw);
		logic [7:0] d, t, k;
		logic [2:0] b;
		logic [6:0] io;
		logic       c;
		wa = {2'b00, opr_m[4:0]};
		d = m[wa];
		b = opb_m[2:0];
		io = IO_BASE + opb_m[7:3];
		k = opb_m[15:8];
		n_m = CYC_ONE;
		c = 1'b0;
		pc_m = pc_m + PC_STEP;
		case (op)
			OP_INDIRECT_CALL, OP_DIRECT_CALL: begin
				t = {7'h00, op == OP_DIRECT_CALL};
				pc_m = pc_m + t;
				m[STK_BASE + sp_m] = pc_m[7:0];
				m[STK_BASE + 6'(sp_m - SP_ONE)] = pc_m[15:8];
				sp_m = sp_m - SP_TWO;
				pc_m = t[0] ? tg_m : z_m;
				n_m = t[0] ? CYC_DIRECT_CALL : CYC_INDIRECT_CALL;
			end
			OP_SUB_RETURN, OP_INT_RETURN: begin
				pc_m = {m[STK_BASE + 6'(sp_m + SP_ONE)],
					m[STK_BASE + 6'(sp_m + SP_TWO)]};
				sp_m = sp_m + SP_TWO;
				n_m = CYC_RETURN;
				if (op == OP_INT_RETURN)
					st_m[FLG_I] = 1'b1;
			end
			OP_CMP_SKIP_EQ: c = d == m[opr_m[9:5]];
			OP_CMP_IMM: begin
				t = d - k;
				st_m[FLG_C] = k > d;
				st_m[FLG_Z] = t == 8'h00;
				st_m[FLG_N] = t[7];
				st_m[FLG_V] = d[7] & ~k[7] & ~t[7] | ~d[7] & k[7] & t[7];
				st_m[FLG_H] = ~d[3] & k[3] | k[3] & t[3] | t[3] & ~d[3];
			end
			OP_SKIP_REG_CLR: c = !d[b];
			OP_SKIP_REG_SET: c = d[b];
			OP_SKIP_IO_CLR: c = !m[io][b];
			OP_SKIP_IO_SET: c = m[io][b];
			OP_BRANCH_FLAG_SET: c = st_m[b];
			OP_BRANCH_FLAG_CLR: c = !st_m[b];
			OP_BRANCH_SIGNED_GE: c = !(st_m[FLG_N] ^ st_m[FLG_V]);
			OP_BRANCH_SIGNED_LT: c = st_m[FLG_N] ^ st_m[FLG_V];
			OP_BRANCH_HALF_SET: c = st_m[FLG_H];
			OP_BRANCH_HALF_CLR: c = !st_m[FLG_H];
			OP_BRANCH_OVF_SET: c = st_m[FLG_V];
			OP_BRANCH_OVF_CLR: c = !st_m[FLG_V];
			OP_BRANCH_IRQ_EN: c = st_m[FLG_I];
			OP_BRANCH_IRQ_DIS: c = !st_m[FLG_I];
			OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
				wa = io;
				m[io][b] = op == OP_IO_BIT_SET;
				n_m = CYC_IO_BIT;
			end
			OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
				t = op == OP_ROTATE_LEFT ? {d[6:0], st_m[FLG_C]}
					: {st_m[FLG_C], d[7:1]};
				st_m[FLG_C] = op == OP_ROTATE_LEFT ? d[7] : d[0];
				m[wa] = t;
				st_m[FLG_Z] = t == 8'h00;
				st_m[FLG_N] = t[7];
				st_m[FLG_V] = t[7] ^ st_m[FLG_C];
			end
			OP_NIBBLE_SWAP: m[wa] = {d[3:0], d[7:4]};
			OP_BIT_TO_TFLAG: st_m[FLG_T] = d[b];
			OP_TFLAG_TO_BIT: m[wa][b] = st_m[FLG_T];
			OP_STATUS_SET: st_m[b] = 1'b1;
			default: st_m[b] = 1'b0;
		endcase
		if (c && op < OP_BRANCH_FLAG_SET) begin
			pc_m = pc_m + (tw ? PC_SKIP_ONE : PC_STEP);
			n_m = tw ? CYC_SKIP_TWO : CYC_SKIP_ONE;
		end else if (c) begin
			pc_m = pc_m + {{9{tg_m[6]}}, tg_m[6:0]};
			n_m = CYC_TAKEN;
		end
	endtask

	task automatic run(input logic [4:0] op, input logic tw);
		int          i;
		logic [15:0] g;
		wr(ADDR_CMD, {10'h000, tw, op});
		// Lands while busy, so the operand must stay as it was
		wr(ADDR_OPB, 16'hFFFF);
		model(op, tw);
		i = 0;
		#1;
		while (done !== 1'b1 && i < 20) begin
			@(posedge clk);
			#1;
			i++;
		end
		// A hang counts once and ends the scenario loop
		if (done !== 1'b1) begin
			failures++;
			hung = 1'b1;
			return;
		end
		check("pc", pc_m, pc_out);
		check("status", {8'h00, st_m}, {8'h00, status_out});
		rd(ADDR_CYCLES, g);
		check("cycles", {13'h0000, n_m}, g);
		rd(ADDR_SP, g);
		check("sp", {10'h000, sp_m}, g);
		wr(ADDR_REGADDR, {9'h000, wa});
		rd(ADDR_REGDATA, g);
		check("store", {8'h00, m[wa]}, g);
	endtask

	initial begin
		rst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		failures = 0;
		check_count = 0;
		hung = 1'b0;
		seed = 32'hF19F;
		pc_m = RST_PC;
		z_m = RST_Z;
		st_m = RST_STATUS_REGISTER;
		sp_m = RST_SP;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, unmapped space reads zero
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), v);
			if (a != 9)
				check("reset", a == 7 ? 16'h003F : 16'h0000, v);
		end
		// Store is not reset, so give it known contents
		for (int a = 0; a < MEM_DEPTH; a++) begin
			rnd(v);
			m[a] = v[7:0];
			wr(ADDR_REGADDR, 16'(a));
			wr(ADDR_REGDATA, {8'h00, v[7:0]});
		end
		wr(ADDR_CMD, 16'h001D);
		rd(ADDR_CMD, v);
		check("refused", 16'h0200, v & 16'h0300);
		for (int i = 0; i < 3 * 29 && !hung; i++) begin
			rnd(z_m);
			wr(ADDR_ZPTR, z_m);
			rnd(tg_m);
			wr(ADDR_TARGET, tg_m);
			rnd(opb_m);
			wr(ADDR_OPB, opb_m);
			rnd(opr_m);
			// First pass makes the compared registers equal
			if (i % 29 != 4 || i < 29)
				opr_m[9:5] = opr_m[4:0];
			wr(ADDR_OPR, opr_m);
			rnd(v);
			st_m = v[7:0];
			wr(ADDR_STATUS, {8'h00, v[7:0]});
			run(5'(i % 29), v[8]);
		end
		summarize();
	end
endmodule
